/* hdl/switching_phase_freq_config.sv */
// Contract
// R1: off state means run inputs low or channels commanded off.
// R2: phase byte write applies only when off; else ignored, busy fault.
// R3: bits 2:0 select channel 0/1 phase offsets from sync falling edge.
// R4: bit 6 set limits ch0 to 2.75V, clear to 4.096V.
// R5: bit 5 set limits ch1 to 2.75V, clear to 5.5V.
// R6: host accounts for loop gain change when range bits change.
// R7: share enable holds pin low until above turn-on, again below off.
// R8: share disabled: no pull low at turn-off, only at power up.
// R9: phase command carries exactly one data byte.
// R10: frequency code selects external oscillator or one of eight rates.
// R11: frequency write applies only when off; else ignored, busy fault.
// R12: frequency change when off may report pll lock lost while relocking.
// R13: frequency command carries two bytes, 5-bit exponent, 11-bit mantissa.
// R14: host writes zero to reserved bits 7 and 3; device ignores them.
`timescale 1ns/1ps
module switching_phase_freq_config #(
  parameter int RELOCK_CYCLES = pwm_cfg_pkg::RELOCK_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [1:0]  run_i,
  input  wire logic [1:0]  cmd_on_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wr_cmd_i,
  input  wire logic [1:0]  wr_nbytes_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        vin_above_on_i,
  input  wire logic        vin_below_off_i,
  input  wire logic        busy_clr_i,
  output logic [7:0]       phase_cfg_o,
  output logic [15:0]      freq_sel_o,
  output logic [8:0]       ch0_phase_deg_o,
  output logic [8:0]       ch1_phase_deg_o,
  output logic [12:0]      ch0_vmax_mv_o,
  output logic [12:0]      ch1_vmax_mv_o,
  output logic             ext_osc_o,
  output logic             share_clk_o,
  output logic             share_clk_oe_o,
  output logic             busy_fault_o,
  output logic             cml_fault_o,
  output logic             pll_relock_o
);

  // ==========================================================================
  // helper functions
  // ==========================================================================
  // frequency code is one of the supported values
  function automatic logic freq_ok(input logic [15:0] c);
    unique case (c)
      pwm_cfg_pkg::FREQ_EXT_OSC, pwm_cfg_pkg::FREQ_250K,
      pwm_cfg_pkg::FREQ_350K, pwm_cfg_pkg::FREQ_425K,
      pwm_cfg_pkg::FREQ_500K, pwm_cfg_pkg::FREQ_575K,
      pwm_cfg_pkg::FREQ_650K, pwm_cfg_pkg::FREQ_750K,
      pwm_cfg_pkg::FREQ_1000K: freq_ok = 1'b1;
      default:                 freq_ok = 1'b0;
    endcase
  endfunction

  // phase pair for a select code, {ch0, ch1}
  function automatic logic [17:0] phase_pair(input logic [2:0] s);
    unique case (s)
      3'h0:    phase_pair = {pwm_cfg_pkg::DEG_0,   pwm_cfg_pkg::DEG_180};
      3'h1:    phase_pair = {pwm_cfg_pkg::DEG_90,  pwm_cfg_pkg::DEG_270};
      3'h2:    phase_pair = {pwm_cfg_pkg::DEG_0,   pwm_cfg_pkg::DEG_240};
      3'h3:    phase_pair = {pwm_cfg_pkg::DEG_0,   pwm_cfg_pkg::DEG_120};
      3'h4:    phase_pair = {pwm_cfg_pkg::DEG_120, pwm_cfg_pkg::DEG_240};
      3'h5:    phase_pair = {pwm_cfg_pkg::DEG_60,  pwm_cfg_pkg::DEG_240};
      3'h6:    phase_pair = {pwm_cfg_pkg::DEG_120, pwm_cfg_pkg::DEG_300};
      default: phase_pair = {pwm_cfg_pkg::DEG_0,   pwm_cfg_pkg::DEG_180};
    endcase
  endfunction

  // ==========================================================================
  // write decode
  // ==========================================================================
  logic is_off;
  logic wr_phase;
  logic wr_freq;
  logic phase_ok;
  logic freq_good;

  // off when every channel is stopped by pin or command
  assign is_off    = ~|(run_i & cmd_on_i); // [R1]
  assign wr_phase  = wr_i && (wr_cmd_i == pwm_cfg_pkg::CMD_PHASE_CFG);
  assign wr_freq   = wr_i && (wr_cmd_i == pwm_cfg_pkg::CMD_FREQ_SEL);
  // byte counts and codes checked before anything is stored
  assign phase_ok  = (wr_nbytes_i == 2'h1)
                     && (wr_data_i[2:0] != 3'h7); // [R9] [R3]
  assign freq_good = (wr_nbytes_i == 2'h2)
                     && freq_ok(wr_data_i); // [R13] [R10]

  // ==========================================================================
  // configuration registers and faults
  // ==========================================================================
  logic [7:0]  phase_q;
  logic [7:0]  phase_d;
  logic [15:0] freq_q;
  logic [15:0] freq_d;
  logic        busy_q;
  logic        busy_d;
  logic        cml_q;
  logic        cml_d;
  logic [31:0] relock_q;
  logic [31:0] relock_d;

  // next values: apply only when off, flag busy otherwise
  always_comb begin
    phase_d  = phase_q;
    freq_d   = freq_q;
    busy_d   = busy_q;
    cml_d    = cml_q;
    relock_d = (relock_q != 32'h0) ? relock_q - 32'h1 : relock_q;
    if (busy_clr_i) begin
      busy_d = 1'b0;
      cml_d  = 1'b0;
    end
    if (wr_phase) begin
      if (!is_off) begin
        busy_d = 1'b1; // [R2]
      end else if (!phase_ok) begin
        cml_d = 1'b1;
      end else begin
        phase_d = wr_data_i[7:0] & pwm_cfg_pkg::PHASE_CFG_MASK; // [R2] [R14]
      end
    end
    if (wr_freq) begin
      if (!is_off) begin
        busy_d = 1'b1; // [R11]
      end else if (!freq_good) begin
        cml_d = 1'b1;
      end else begin
        freq_d = wr_data_i; // [R11]
        if (wr_data_i != freq_q) begin
          relock_d = 32'(RELOCK_CYCLES); // [R12]
        end
      end
    end
  end

  // register configuration state
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q  <= pwm_cfg_pkg::PHASE_CFG_RST;
      freq_q   <= pwm_cfg_pkg::FREQ_SEL_RST;
      busy_q   <= 1'b0;
      cml_q    <= 1'b0;
      relock_q <= 32'h0;
    end else begin
      phase_q  <= phase_d;
      freq_q   <= freq_d;
      busy_q   <= busy_d;
      cml_q    <= cml_d;
      relock_q <= relock_d;
    end
  end

  // ==========================================================================
  // shared clock pin
  // ==========================================================================
  share_clk_if sc ();

  assign sc.share_en      = phase_q[pwm_cfg_pkg::BIT_SHARE_EN]; // [R7] [R8]
  assign sc.vin_above_on  = vin_above_on_i;
  assign sc.vin_below_off = vin_below_off_i;

  share_clk_gate u_gate (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sc        (sc)
  );

  // ==========================================================================
  // decoded outputs, all registered
  // ==========================================================================
  logic [17:0] pair_d;
  logic [12:0] v0_d;
  logic [12:0] v1_d;

  // phase pair and range limits from the next phase byte, phase_d
  always_comb begin
    pair_d = phase_pair(phase_d[pwm_cfg_pkg::PHASE_SEL_MSB:0]); // [R3]
    v0_d   = phase_d[pwm_cfg_pkg::BIT_CH0_RANGE]
             ? pwm_cfg_pkg::VMAX_LOW_MV
             : pwm_cfg_pkg::VMAX_CH0_HI_MV; // [R4]
    v1_d   = phase_d[pwm_cfg_pkg::BIT_CH1_RANGE]
             ? pwm_cfg_pkg::VMAX_LOW_MV
             : pwm_cfg_pkg::VMAX_CH1_HI_MV; // [R5]
  end

  // output flops
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_cfg_o     <= pwm_cfg_pkg::PHASE_CFG_RST;
      freq_sel_o      <= pwm_cfg_pkg::FREQ_SEL_RST;
      ch0_phase_deg_o <= pwm_cfg_pkg::DEG_0;
      ch1_phase_deg_o <= pwm_cfg_pkg::DEG_180;
      ch0_vmax_mv_o   <= pwm_cfg_pkg::VMAX_CH0_HI_MV;
      ch1_vmax_mv_o   <= pwm_cfg_pkg::VMAX_CH1_HI_MV;
      ext_osc_o       <= 1'b0;
      share_clk_o     <= 1'b0;
      share_clk_oe_o  <= 1'b1;
      busy_fault_o    <= 1'b0;
      cml_fault_o     <= 1'b0;
      pll_relock_o    <= 1'b0;
    end else begin
      phase_cfg_o     <= phase_d;
      freq_sel_o      <= freq_d;
      ch0_phase_deg_o <= pair_d[17:9];
      ch1_phase_deg_o <= pair_d[8:0];
      ch0_vmax_mv_o   <= v0_d;
      ch1_vmax_mv_o   <= v1_d;
      ext_osc_o       <= (freq_d == pwm_cfg_pkg::FREQ_EXT_OSC); // [R10]
      share_clk_o     <= 1'b0;
      share_clk_oe_o  <= sc.hold_low; // [R7] [R8]
      busy_fault_o    <= busy_d;
      cml_fault_o     <= cml_d;
      pll_relock_o    <= (relock_d != 32'h0); // [R12]
    end
  end

endmodule

/* hdl/pwm_cfg_pkg.sv */
package pwm_cfg_pkg;

  // ==========================================================================
  // command codes and widths
  // ==========================================================================
  localparam logic [7:0]  CMD_PHASE_CFG    = 8'hF5;
  localparam logic [7:0]  CMD_FREQ_SEL     = 8'h33;
  localparam int          PHASE_CFG_W      = 8;
  localparam int          FREQ_SEL_W       = 16;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0]  PHASE_CFG_RST    = 8'h10;
  localparam logic [15:0] FREQ_SEL_RST     = 16'hFABC;

  // ==========================================================================
  // phase byte field positions
  // ==========================================================================
  localparam int          BIT_CH0_RANGE    = 6;
  localparam int          BIT_CH1_RANGE    = 5;
  localparam int          BIT_SHARE_EN     = 4;
  localparam int          PHASE_SEL_MSB    = 2;
  localparam logic [7:0]  PHASE_CFG_MASK   = 8'h77;

  // ==========================================================================
  // supported frequency codes
  // ==========================================================================
  localparam logic [15:0] FREQ_EXT_OSC     = 16'h0000;
  localparam logic [15:0] FREQ_250K        = 16'hF3E8;
  localparam logic [15:0] FREQ_350K        = 16'hFABC;
  localparam logic [15:0] FREQ_425K        = 16'hFB52;
  localparam logic [15:0] FREQ_500K        = 16'hFBE8;
  localparam logic [15:0] FREQ_575K        = 16'h023F;
  localparam logic [15:0] FREQ_650K        = 16'h028A;
  localparam logic [15:0] FREQ_750K        = 16'h02EE;
  localparam logic [15:0] FREQ_1000K       = 16'h03E8;

  // ==========================================================================
  // phase offsets in degrees, ch0 and ch1
  // ==========================================================================
  localparam logic [8:0]  DEG_0            = 9'h000;
  localparam logic [8:0]  DEG_60           = 9'h03C;
  localparam logic [8:0]  DEG_90           = 9'h05A;
  localparam logic [8:0]  DEG_120          = 9'h078;
  localparam logic [8:0]  DEG_180          = 9'h0B4;
  localparam logic [8:0]  DEG_240          = 9'h0F0;
  localparam logic [8:0]  DEG_270          = 9'h10E;
  localparam logic [8:0]  DEG_300          = 9'h12C;

  // ==========================================================================
  // output range limits in millivolts
  // ==========================================================================
  localparam logic [12:0] VMAX_LOW_MV      = 13'h0ABE;
  localparam logic [12:0] VMAX_CH0_HI_MV   = 13'h1000;
  localparam logic [12:0] VMAX_CH1_HI_MV   = 13'h157C;

  // ==========================================================================
  // pll relock window after a frequency change
  // ==========================================================================
  localparam int          RELOCK_TIME_US   = 100;
  localparam int          CLK_MHZ          = 40;
  localparam int          RELOCK_CYCLES    = RELOCK_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SH_INIT,
    SH_RELEASED,
    SH_HELD
  } share_state_t;

endpackage

/* hdl/share_clk_if.sv */
`timescale 1ns/1ps
interface share_clk_if;
  logic share_en;
  logic vin_above_on;
  logic vin_below_off;
  logic hold_low;

  modport ctrl (output share_en, vin_above_on, vin_below_off,
                input hold_low);
  modport gate (input share_en, vin_above_on, vin_below_off,
                output hold_low);
endinterface

/* hdl/share_clk_gate.sv */
`timescale 1ns/1ps
module share_clk_gate (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  share_clk_if.gate sc
);

  pwm_cfg_pkg::share_state_t state_q;
  pwm_cfg_pkg::share_state_t state_d;

  // ==========================================================================
  // release policy of the shared clock pin
  // ==========================================================================
  // next state: held low at power up until input rises past turn-on
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pwm_cfg_pkg::SH_INIT: begin
        if (sc.vin_above_on) begin
          state_d = pwm_cfg_pkg::SH_RELEASED; // [R8] [R7]
        end
      end
      pwm_cfg_pkg::SH_RELEASED: begin
        if (sc.share_en && sc.vin_below_off) begin
          state_d = pwm_cfg_pkg::SH_HELD; // [R7]
        end
      end
      pwm_cfg_pkg::SH_HELD: begin
        if (!sc.share_en) begin
          state_d = pwm_cfg_pkg::SH_RELEASED; // [R8]
        end else if (sc.vin_above_on) begin
          state_d = pwm_cfg_pkg::SH_RELEASED; // [R7]
        end
      end
      default: state_d = pwm_cfg_pkg::SH_INIT;
    endcase
  end

  // register state
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= pwm_cfg_pkg::SH_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  assign sc.hold_low = (state_d != pwm_cfg_pkg::SH_RELEASED);

endmodule

/* verif/pmbus_host_model.sv */
`timescale 1ns/1ps
// ==================================================
// host side: turns a go pulse into one write strobe
module pmbus_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        go_i,
  input  wire logic        bad_n_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [15:0] val_i,
  output logic             wr_o = 1'b0,
  output logic [7:0]       wr_cmd_o = 8'h00,
  output logic [1:0]       wr_nbytes_o = 2'h0,
  output logic [15:0]      wr_data_o = 16'h0000
);
  logic fq;
  assign fq = (cmd_i == pwm_cfg_pkg::CMD_FREQ_SEL);
  // strobe for one cycle; idle lines flip every cycle
  always_ff @(posedge clk_sys_i) begin
    wr_o <= go_i;
    if (go_i) begin
      wr_cmd_o <= cmd_i;
      wr_nbytes_o <= (fq != bad_n_i) ? 2'h2 : 2'h1;
      wr_data_o <= fq ? val_i : (val_i & 16'h0077);
    end else begin
      wr_cmd_o <= ~wr_cmd_o;
      wr_nbytes_o <= ~wr_nbytes_o;
      wr_data_o <= ~wr_data_o;
    end
  end
endmodule

/* verif/switching_phase_freq_config_properties.sv */
`timescale 1ns/1ps
// ==================================================
// port checker for the phase and frequency config
module spfc_checker #(
  parameter int RELOCK_CYCLES = 8
) (
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic [1:0]  run_i,
  input wire logic [1:0]  cmd_on_i,
  input wire logic        wr_i,
  input wire logic [7:0]  wr_cmd_i,
  input wire logic [1:0]  wr_nbytes_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        vin_above_on_i,
  input wire logic        vin_below_off_i,
  input wire logic [7:0]  phase_cfg_o,
  input wire logic [15:0] freq_sel_o,
  input wire logic [12:0] ch0_vmax_mv_o,
  input wire logic [12:0] ch1_vmax_mv_o,
  input wire logic        ext_osc_o,
  input wire logic        share_clk_oe_o,
  input wire logic        busy_fault_o,
  input wire logic        pll_relock_o
);
  logic        run;
  logic        wr_ph;
  logic        wr_fq;
  logic [15:0] rl_cnt_q;
  logic [15:0] rl_cnt_d;
  // decode of write kinds and running state
  assign run = |(run_i & cmd_on_i);
  assign wr_ph = wr_i && wr_cmd_i == pwm_cfg_pkg::CMD_PHASE_CFG;
  assign wr_fq = wr_i && wr_cmd_i == pwm_cfg_pkg::CMD_FREQ_SEL;
  // length of the running relock window
  always_comb begin
    rl_cnt_d = pll_relock_o ? rl_cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rl_cnt_q <= 16'h0000;
    end else begin
      rl_cnt_q <= rl_cnt_d;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_phase_busy;
    wr_ph && run |=> busy_fault_o && $stable(phase_cfg_o);
  endproperty
  a_phase_busy: assert property (p_phase_busy)
    else $error("phase write while running not refused");
  property p_phase_apply;
    wr_ph && !run && wr_nbytes_i == 2'h1 && wr_data_i[2:0] != 3'h7
      |=> {8'h00, phase_cfg_o} == ($past(wr_data_i) & 16'h0077);
  endproperty
  a_phase_apply: assert property (p_phase_apply)
    else $error("phase write while off not stored");
  property p_freq_busy;
    wr_fq && run |=> busy_fault_o && $stable(freq_sel_o);
  endproperty
  a_freq_busy: assert property (p_freq_busy)
    else $error("frequency write while running not refused");
  property p_vmax0;
    ch0_vmax_mv_o == (phase_cfg_o[6] ? pwm_cfg_pkg::VMAX_LOW_MV
                                     : pwm_cfg_pkg::VMAX_CH0_HI_MV);
  endproperty
  a_vmax0: assert property (p_vmax0)
    else $error("channel 0 range limit wrong");
  property p_vmax1;
    ch1_vmax_mv_o == (phase_cfg_o[5] ? pwm_cfg_pkg::VMAX_LOW_MV
                                     : pwm_cfg_pkg::VMAX_CH1_HI_MV);
  endproperty
  a_vmax1: assert property (p_vmax1)
    else $error("channel 1 range limit wrong");
  property p_ext_osc;
    ext_osc_o == (freq_sel_o == pwm_cfg_pkg::FREQ_EXT_OSC);
  endproperty
  a_ext_osc: assert property (p_ext_osc)
    else $error("external oscillator flag wrong");
  property p_share_hold;
    phase_cfg_o[4] && vin_below_off_i && !vin_above_on_i
      |=> share_clk_oe_o;
  endproperty
  a_share_hold: assert property (p_share_hold)
    else $error("shared clock not pulled low below turn-off");
  property p_share_rel;
    share_clk_oe_o && vin_above_on_i && !vin_below_off_i
      |-> ##[1:2] !share_clk_oe_o;
  endproperty
  a_share_rel: assert property (p_share_rel)
    else $error("shared clock not released above turn-on");
  property p_share_keep;
    !share_clk_oe_o && !phase_cfg_o[4] |=> !share_clk_oe_o;
  endproperty
  a_share_keep: assert property (p_share_keep)
    else $error("shared clock pulled low with sharing off");
  property p_relock_len;
    $fell(pll_relock_o) |-> rl_cnt_q == RELOCK_CYCLES;
  endproperty
  a_relock_len: assert property (p_relock_len)
    else $error("relock window length wrong");
endmodule
bind switching_phase_freq_config spfc_checker #(
  .RELOCK_CYCLES(RELOCK_CYCLES)
) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .run_i(run_i),
  .cmd_on_i(cmd_on_i), .wr_i(wr_i), .wr_cmd_i(wr_cmd_i),
  .wr_nbytes_i(wr_nbytes_i), .wr_data_i(wr_data_i),
  .vin_above_on_i(vin_above_on_i), .vin_below_off_i(vin_below_off_i),
  .phase_cfg_o(phase_cfg_o), .freq_sel_o(freq_sel_o),
  .ch0_vmax_mv_o(ch0_vmax_mv_o), .ch1_vmax_mv_o(ch1_vmax_mv_o),
  .ext_osc_o(ext_osc_o), .share_clk_oe_o(share_clk_oe_o),
  .busy_fault_o(busy_fault_o), .pll_relock_o(pll_relock_o)
);

/* verif/switching_phase_freq_config_tb_top.sv */
`timescale 1ns/1ps
// ==================================================
// bench top for the phase and frequency config block
module switching_phase_freq_config_tb_top;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        go, bad_n, wr, busy_clr, input_turn_on_threshold, input_turn_off_threshold;
  logic [1:0]  run, cmd_on, nby;
  logic [7:0]  cmd, wcmd, ph;
  logic [15:0] val, wdat, fq;
  logic [8:0]  d0, d1;
  logic [12:0] v0, v1;
  logic        ext, shc, shc_oe, busy, cml, relock;
  int          n_mismatch;
  int          num_checks;
  logic [15:0] codes [9] = '{16'h0000, 16'hF3E8, 16'hFABC, 16'hFB52,
    16'hFBE8, 16'h023F, 16'h028A, 16'h02EE, 16'h03E8};

  pmbus_host_model host (.clk_sys_i(clk_sys_i), .go_i(go),
    .bad_n_i(bad_n), .cmd_i(cmd), .val_i(val), .wr_o(wr),
    .wr_cmd_o(wcmd), .wr_nbytes_o(nby), .wr_data_o(wdat));
  switching_phase_freq_config #(.RELOCK_CYCLES(8)) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .run_i(run),
    .cmd_on_i(cmd_on), .wr_i(wr), .wr_cmd_i(wcmd), .wr_nbytes_i(nby),
    .wr_data_i(wdat), .vin_above_on_i(input_turn_on_threshold), .vin_below_off_i(input_turn_off_threshold),
    .busy_clr_i(busy_clr), .phase_cfg_o(ph), .freq_sel_o(fq),
    .ch0_phase_deg_o(d0), .ch1_phase_deg_o(d1), .ch0_vmax_mv_o(v0),
    .ch1_vmax_mv_o(v1), .ext_osc_o(ext), .share_clk_o(shc),
    .share_clk_oe_o(shc_oe), .busy_fault_o(busy), .cml_fault_o(cml),
    .pll_relock_o(relock));

  // ==================================================
  // helpers
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // one command through the host, settled after the taking edge
  task automatic send(input logic [7:0] c, input logic [15:0] v,
                      input logic b);
    @(posedge clk_sys_i);
    go <= 1'b1;
    cmd <= c;
    val <= v;
    bad_n <= b;
    @(posedge clk_sys_i);
    go <= 1'b0;
    tick(2);
  endtask
  task automatic clr();
    @(posedge clk_sys_i);
    busy_clr <= 1'b1;
    @(posedge clk_sys_i);
    busy_clr <= 1'b0;
    tick(1);
  endtask
  // expected channel 0 and 1 offsets for a phase code
  function automatic logic [17:0] degs(input logic [2:0] c);
    case (c)
      3'h0: degs = {pwm_cfg_pkg::DEG_0, pwm_cfg_pkg::DEG_180};
      3'h1: degs = {pwm_cfg_pkg::DEG_90, pwm_cfg_pkg::DEG_270};
      3'h2: degs = {pwm_cfg_pkg::DEG_0, pwm_cfg_pkg::DEG_240};
      3'h3: degs = {pwm_cfg_pkg::DEG_0, pwm_cfg_pkg::DEG_120};
      3'h4: degs = {pwm_cfg_pkg::DEG_120, pwm_cfg_pkg::DEG_240};
      3'h5: degs = {pwm_cfg_pkg::DEG_60, pwm_cfg_pkg::DEG_240};
      default: degs = {pwm_cfg_pkg::DEG_120, pwm_cfg_pkg::DEG_300};
    endcase
  endfunction

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ==================================================
  // main sequence
  initial begin
    logic [7:0]  b;
    logic [7:0]  keep;
    logic [15:0] c;
    logic [15:0] prev;
    logic [17:0] dd;
    int          s;
    {resetn_i, go, bad_n, busy_clr, input_turn_on_threshold, input_turn_off_threshold} = 6'h00;
    {run, cmd_on, cmd, val} = 28'h0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(82));
    tick(20);
    chk(ph, pwm_cfg_pkg::PHASE_CFG_RST);
    chk(fq, pwm_cfg_pkg::FREQ_SEL_RST);
    chk(shc_oe, 1'b1);
    chk(busy, 1'b0);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    input_turn_on_threshold <= 1'b1;
    tick(3);
    chk(shc_oe, 1'b0);
    // every phase code with random range and share bits
    for (int i = 0; i < 8; i++) begin
      b = {1'b0, 3'($urandom), 1'b0, i[2:0]};
      send(pwm_cfg_pkg::CMD_PHASE_CFG, {8'h00, b}, 1'b0);
      dd = degs(i[2:0]);
      if (i == 7) begin
        chk(cml, 1'b1);
        chk(ph, keep);
      end else begin
        keep = b;
        chk(ph, b);
        chk(d0, dd[17:9]);
        chk(d1, dd[8:0]);
        chk(v0, b[6] ? 13'h0ABE : 13'h1000);
        chk(v1, b[5] ? 13'h0ABE : 13'h157C);
      end
    end
    clr();
    send(pwm_cfg_pkg::CMD_PHASE_CFG, 16'h0001, 1'b1);
    chk(cml, 1'b1);
    chk(ph, keep);
    // channel 1 running: both writes refused
    @(posedge clk_sys_i);
    run <= 2'h2;
    cmd_on <= 2'h2;
    send(pwm_cfg_pkg::CMD_PHASE_CFG, 16'h0003, 1'b0);
    chk(busy, 1'b1);
    chk(ph, keep);
    send(pwm_cfg_pkg::CMD_FREQ_SEL, 16'h03E8, 1'b0);
    chk(fq, pwm_cfg_pkg::FREQ_SEL_RST);
    // run pin and on command never both high: counts as off
    @(posedge clk_sys_i);
    run <= 2'h1;
    send(pwm_cfg_pkg::CMD_PHASE_CFG, 16'h0000, 1'b0);
    chk(ph, 16'h0000);
    clr();
    chk(busy, 1'b0);
    chk(cml, 1'b0);
    // all frequency codes from a random start
    s = $urandom % 9;
    prev = pwm_cfg_pkg::FREQ_SEL_RST;
    for (int i = 0; i < 9; i++) begin
      c = codes[(i + s) % 9];
      send(pwm_cfg_pkg::CMD_FREQ_SEL, c, 1'b0);
      chk(fq, c);
      chk(ext, c == 16'h0000);
      chk(relock, c != prev);
      prev = c;
      for (int k = 0; relock !== 1'b0; k++) begin
        if (k > 20) begin
          n_mismatch++;
          test_done();
        end
        tick(1);
      end
    end
    send(pwm_cfg_pkg::CMD_FREQ_SEL, 16'h1234, 1'b0);
    chk(cml, 1'b1);
    clr();
    send(pwm_cfg_pkg::CMD_FREQ_SEL, 16'hFB52, 1'b1);
    chk(cml, 1'b1);
    chk(fq, prev);
    // shared clock pin against the input thresholds
    send(pwm_cfg_pkg::CMD_PHASE_CFG, 16'h0010, 1'b0);
    @(posedge clk_sys_i);
    input_turn_on_threshold <= 1'b0;
    input_turn_off_threshold <= 1'b1;
    tick(2);
    chk(shc_oe, 1'b1);
    @(posedge clk_sys_i);
    input_turn_off_threshold <= 1'b0;
    input_turn_on_threshold <= 1'b1;
    tick(3);
    chk(shc_oe, 1'b0);
    send(pwm_cfg_pkg::CMD_PHASE_CFG, 16'h0000, 1'b0);
    @(posedge clk_sys_i);
    input_turn_on_threshold <= 1'b0;
    input_turn_off_threshold <= 1'b1;
    tick(3);
    chk(shc_oe, 1'b0);
    chk(shc, 1'b0);
    test_done();
  end
endmodule
